//--- rtl/svlr_pkg.sv
// constants and types for the supply low-voltage reset control block
package svlr_pkg;

   // ****************************************
   // bus and register map
   // ****************************************
   localparam int SVLR_ADDR_W = 12;
   localparam logic [11:0] SVLR_CFG_OFF = 12'h000;
   localparam logic [11:0] SVLR_STATUS_OFF = 12'h004;

   // config_register_one field positions
   localparam int SVLR_CFG_PWRD_BIT = 0;
   localparam int SVLR_CFG_RSTD_BIT = 1;
   localparam int SVLR_CFG_STOP_BIT = 2;
   localparam int SVLR_CFG_TRIP_BIT = 3;
   // low_voltage_status field position
   localparam int SVLR_STAT_FLAG_BIT = 7;

   // reset values: monitor on, resets on, stop off, low threshold
   localparam logic SVLR_PWRD_RST = 1'b0;
   localparam logic SVLR_RSTD_RST = 1'b0;
   localparam logic SVLR_STOP_RST = 1'b0;
   localparam logic SVLR_TRIP_RST = 1'b0;
   localparam logic SVLR_FLAG_RST = 1'b0;

   // program start fetched after a low-voltage reset
   localparam logic [15:0] SVLR_RESET_VECTOR = 16'hFFFE;

   // ****************************************
   // timing
   // ****************************************
   localparam int SVLR_CLK_PERIOD_PS = 8000;
   // comparator settling after a threshold change, least time
   localparam int SVLR_SETTLE_NS = 1000;
   localparam int SVLR_SETTLE_CYC_INT =
      (SVLR_SETTLE_NS * 1000 + SVLR_CLK_PERIOD_PS - 1) / SVLR_CLK_PERIOD_PS;
   localparam logic [7:0] SVLR_SETTLE_CYC = 8'(SVLR_SETTLE_CYC_INT);

   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic trip_level_select;
      logic monitor_stop_enable;
      logic monitor_reset_disable;
      logic monitor_power_disable;
   } svlr_cfg_t;

   typedef struct packed {
      logic below_fall;
      logic above_rise;
   } svlr_cmp_t;

   typedef enum logic [1:0] {
      SVLR_ST_WATCH,
      SVLR_ST_SETTLE,
      SVLR_ST_HOLD
   } svlr_state_t;

endpackage

//--- rtl/svlr_sync.sv
// two-flop synchroniser for the comparator levels
`timescale 1ns/100ps
`default_nettype none
module svlr_sync #(
   parameter int WIDTH = 2
) (
   input wire logic i_sys_clk,            // bus clock
   input wire logic i_rst_n,              // sync reset, active low
   input wire logic [WIDTH-1:0] i_async,  // levels from the analog side
   output logic [WIDTH-1:0] o_sync        // synchronised levels
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         meta_reg <= '0;
         o_sync <= '0;
      end else begin
         meta_reg <= i_async;
         o_sync <= meta_reg;
      end
   end
endmodule
`default_nettype wire

//--- rtl/svlr_lvflag.sv
// hysteretic below-trip status flag
`timescale 1ns/100ps
`default_nettype none
module svlr_lvflag
   import svlr_pkg::*;
(
   input wire logic i_sys_clk,   // bus clock
   input wire logic i_rst_n,     // sync reset, active low
   input wire logic i_update_en, // monitor active and settled
   input wire logic i_below,     // below falling trip, synchronised
   input wire logic i_above,     // above rising trip, synchronised
   output logic o_flag           // below_trip_flag
);
   // set below, clear above, hold between
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_flag <= SVLR_FLAG_RST;
      end else if (i_update_en && i_below) begin
         o_flag <= 1'b1;
      end else if (i_update_en && i_above) begin
         o_flag <= 1'b0;
      end
   end

   a_flag_sets: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_update_en && i_below |=> o_flag)
      else $error("flag did not set below the falling trip");

   a_flag_clears: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_update_en && i_above && !i_below |=> !o_flag)
      else $error("flag did not clear above the rising trip");
endmodule
`default_nettype wire

//--- rtl/svlr_top.sv
// supply low-voltage reset control with APB register access
//
// Contract
// - after reset the monitor is enabled with no software action.
// - the supply is watched only while monitor_power_disable is zero.
// - with resets enabled and the monitor on, a fall below the falling trip requests reset.
// - in stop mode the monitor runs only if monitor_stop_enable is one.
// - trip_level_select one picks the higher threshold, zero the lower.
// - every power-on reset puts trip_level_select back to the lower threshold.
// - selecting the higher threshold while not above its rising trip enters reset at once; the code enters it only after the settle time.
// - a low-voltage reset holds until the supply rises above the rising trip; the code also releases it when monitor_power_disable is set.
// - a low-voltage reset also pulls the external reset pin low.
// - the status flag is one below falling trip, zero above rising trip, else held.
// - any reset clears the status flag.
// - the monitor never raises an interrupt request.
// - when enabled the monitor stays active in wait mode and its reset ends wait.
// - with stop enable set the monitor stays active in stop and its reset ends stop.
// - a reset that ends stop restarts clocks and fetches the reset vector.
`timescale 1ns/100ps
`default_nettype none
module svlr_top
   import svlr_pkg::*;
(
   input wire logic i_sys_clk,                      // bus clock, 125 MHz
   input wire logic i_rst_n,                        // system reset, sync, active low
   input wire logic i_por_n,                        // power-on reset, sync, active low
   input wire logic i_psel,                         // apb select
   input wire logic i_penable,                      // apb enable
   input wire logic i_pwrite,                       // apb write
   input wire logic [svlr_pkg::SVLR_ADDR_W-1:0] i_paddr, // apb byte address
   input wire logic [31:0] i_pwdata,                // apb write data
   output logic [31:0] o_prdata,                    // apb read data
   output logic o_pready,                           // apb ready
   output logic o_pslverr,                          // apb error, unmapped address
   input wire logic i_below_fall_async,             // comparator: below falling trip
   input wire logic i_above_rise_async,             // comparator: above rising trip
   input wire logic i_wait_mode,                    // core is in wait mode
   input wire logic i_stop_mode,                    // core is in stop mode
   output logic o_monitor_power_en,                 // powers the comparator
   output logic o_trip_level_select,                // higher threshold when high
   output logic o_lv_reset_req,                     // reset request to system
   output logic o_rst_pin_out,                      // reset pin drive level
   output logic o_rst_pin_oe,                       // reset pin enable, high drives
   output logic o_wake_pulse,                       // ends wait or stop, one cycle
   output logic [15:0] o_wake_vector                // start address after the wake
);
   import svlr_pkg::*;

   // ****************************************
   // comparator synchronisation
   // ****************************************
   svlr_cmp_t cmp;
   logic [1:0] cmp_sync;

   svlr_sync #(.WIDTH(2)) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_async({i_below_fall_async, i_above_rise_async}),
      .o_sync(cmp_sync)
   );
   assign cmp = svlr_cmp_t'(cmp_sync);

   // ****************************************
   // apb slave, one wait state
   // ****************************************
   // ready comes from a flop, so every access takes two access cycles
   logic apb_access;
   logic apb_done;
   logic hit_cfg;
   logic hit_stat;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rd_mux;
   logic cfg_wr;
   svlr_cfg_t cfg_reg;
   logic flag;

   assign apb_access = i_psel && i_penable;
   assign apb_done = apb_access && pready_reg;
   assign hit_cfg = (i_paddr == SVLR_CFG_OFF);
   assign hit_stat = (i_paddr == SVLR_STATUS_OFF);
   assign cfg_wr = apb_done && i_pwrite && hit_cfg;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_cfg) begin
         rd_mux[SVLR_CFG_PWRD_BIT] = cfg_reg.monitor_power_disable;
         rd_mux[SVLR_CFG_RSTD_BIT] = cfg_reg.monitor_reset_disable;
         rd_mux[SVLR_CFG_STOP_BIT] = cfg_reg.monitor_stop_enable;
         rd_mux[SVLR_CFG_TRIP_BIT] = cfg_reg.trip_level_select;
      end else if (hit_stat) begin
         rd_mux[SVLR_STAT_FLAG_BIT] = flag;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= apb_access && !pready_reg;
      end
   end

   // data and error only stand in the ready cycle
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (apb_access && !pready_reg) begin
         prdata_reg <= i_pwrite ? 32'h0000_0000 : rd_mux;
         pslverr_reg <= !(hit_cfg || hit_stat);
      end else begin
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end
   end

   assign o_pready = pready_reg;
   assign o_prdata = prdata_reg;
   assign o_pslverr = pslverr_reg;

   // ****************************************
   // configuration bits
   // ****************************************
   logic raise_high;

   // monitor and resets on after reset
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         cfg_reg.monitor_power_disable <= SVLR_PWRD_RST;
         cfg_reg.monitor_reset_disable <= SVLR_RSTD_RST;
         cfg_reg.monitor_stop_enable <= SVLR_STOP_RST;
      end else if (cfg_wr) begin
         cfg_reg.monitor_power_disable <= i_pwdata[SVLR_CFG_PWRD_BIT];
         cfg_reg.monitor_reset_disable <= i_pwdata[SVLR_CFG_RSTD_BIT];
         cfg_reg.monitor_stop_enable <= i_pwdata[SVLR_CFG_STOP_BIT];
      end
   end

   // only power-on reset restores the low threshold
   // the analog side picks its threshold from this bit
   always_ff @(posedge i_sys_clk) begin
      if (!i_por_n) begin
         cfg_reg.trip_level_select <= SVLR_TRIP_RST;
      end else if (cfg_wr) begin
         cfg_reg.trip_level_select <= i_pwdata[SVLR_CFG_TRIP_BIT];
      end
   end
   assign o_trip_level_select = cfg_reg.trip_level_select;

   assign raise_high = cfg_wr && i_pwdata[SVLR_CFG_TRIP_BIT] && !cfg_reg.trip_level_select;

   // ****************************************
   // monitor gating
   // ****************************************
   logic monitor_active;
   logic power_en_reg;

   // stop mode needs the stop enable
   // wait mode does not gate the monitor
   assign monitor_active = !cfg_reg.monitor_power_disable &&
                           (!i_stop_mode || cfg_reg.monitor_stop_enable);

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         power_en_reg <= 1'b0;
      end else begin
         power_en_reg <= monitor_active;
      end
   end
   assign o_monitor_power_en = power_en_reg;

   // ****************************************
   // trip state machine
   // ****************************************
   // the comparator reads the old threshold right after a raise, so the
   // "at once" check waits out the settle time before deciding
   svlr_state_t state_reg;
   svlr_state_t state_next;
   logic [7:0] settle_cnt_reg;
   logic trip_fall;

   assign trip_fall = monitor_active && !cfg_reg.monitor_reset_disable && cmp.below_fall;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SVLR_ST_WATCH: begin
            if (trip_fall) begin
               state_next = SVLR_ST_HOLD;
            end else if (raise_high && !cfg_reg.monitor_power_disable) begin
               state_next = SVLR_ST_SETTLE;
            end
         end
         // decide once the new threshold has settled
         SVLR_ST_SETTLE: begin
            if (cfg_reg.monitor_power_disable) begin
               state_next = SVLR_ST_WATCH;
            end else if (trip_fall) begin
               state_next = SVLR_ST_HOLD;
            end else if (settle_cnt_reg == 8'h00) begin
               state_next = cmp.above_rise ? SVLR_ST_WATCH : SVLR_ST_HOLD;
            end
         end
         // hold until the rising trip is passed or monitor_power_disable is set
         SVLR_ST_HOLD: begin
            if (cfg_reg.monitor_power_disable || cmp.above_rise) begin
               state_next = SVLR_ST_WATCH;
            end
         end
         default: begin
            state_next = SVLR_ST_WATCH;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         state_reg <= SVLR_ST_WATCH;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         settle_cnt_reg <= 8'h00;
      end else if (state_reg != SVLR_ST_SETTLE && state_next == SVLR_ST_SETTLE) begin
         settle_cnt_reg <= SVLR_SETTLE_CYC - 8'h01;
      end else if (settle_cnt_reg != 8'h00) begin
         settle_cnt_reg <= settle_cnt_reg - 8'h01;
      end
   end

   // ****************************************
   // reset request, pin and wake
   // ****************************************
   // no interrupt output exists; reset and flag are the only results
   logic hold_next;
   logic req_reg;
   logic pin_oe_reg;
   logic pin_out_reg;
   logic wake_reg;
   logic [15:0] vector_reg;

   assign hold_next = (state_next == SVLR_ST_HOLD);

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         req_reg <= 1'b0;
      end else begin
         req_reg <= hold_next;
      end
   end

   // open-drain low drive while the reset stands
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         pin_oe_reg <= 1'b0;
         pin_out_reg <= 1'b0;
      end else begin
         pin_oe_reg <= hold_next;
         pin_out_reg <= 1'b0;
      end
   end

   // new reset in wait ends wait
   // new reset in stop ends stop
   // wake carries the reset vector for the clock restart
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         wake_reg <= 1'b0;
         vector_reg <= SVLR_RESET_VECTOR;
      end else begin
         wake_reg <= hold_next && (state_reg != SVLR_ST_HOLD) && (i_stop_mode || i_wait_mode);
         vector_reg <= SVLR_RESET_VECTOR;
      end
   end

   assign o_lv_reset_req = req_reg;
   assign o_rst_pin_oe = pin_oe_reg;
   assign o_rst_pin_out = pin_out_reg;
   assign o_wake_pulse = wake_reg;
   assign o_wake_vector = vector_reg;

   // ****************************************
   // status flag
   // ****************************************
   // flag frozen while the threshold settles
   svlr_lvflag u_flag (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_update_en(monitor_active && state_reg != SVLR_ST_SETTLE),
      .i_below(cmp.below_fall),
      .i_above(cmp.above_rise),
      .o_flag(flag)
   );

   // ****************************************
   // checks
   // ****************************************
   // reset leaves monitor and resets on
   a_reset_monitor_on: assert property (
      @(posedge i_sys_clk) !i_rst_n |=> !cfg_reg.monitor_power_disable &&
         !cfg_reg.monitor_reset_disable)
      else $error("monitor not enabled after reset");

   a_power_off_quiet: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      cfg_reg.monitor_power_disable |=> !o_lv_reset_req && !o_monitor_power_en)
      else $error("request while monitor powered down");

   // falling trip requests reset next cycle
   a_fall_requests: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      monitor_active && !cfg_reg.monitor_reset_disable && cmp.below_fall
      |=> o_lv_reset_req)
      else $error("no reset after falling trip");

   // stopped without stop enable keeps flag still
   a_stop_gating: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_stop_mode && !cfg_reg.monitor_stop_enable |=> flag == $past(flag))
      else $error("flag moved in stop without stop enable");

   // power-on reset restores the low threshold
   a_por_low_trip: assert property (
      @(posedge i_sys_clk) !i_por_n |=> !o_trip_level_select)
      else $error("threshold not restored by power-on reset");

   // raise without rising margin ends in reset
   a_raise_enters_reset: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      state_reg == SVLR_ST_SETTLE && settle_cnt_reg == 8'h00 &&
         !cmp.above_rise && !cfg_reg.monitor_power_disable |=> o_lv_reset_req)
      else $error("raise below rising trip did not reset");

   a_hold_until_rise: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      o_lv_reset_req && !cmp.above_rise && !cfg_reg.monitor_power_disable
      |=> o_lv_reset_req)
      else $error("reset released below rising trip");

   // pin driven low with the request
   a_pin_low: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(o_lv_reset_req) |-> o_rst_pin_oe && !o_rst_pin_out ##1
         (o_rst_pin_oe == o_lv_reset_req))
      else $error("reset pin not driven with the request");

   // new reset in stop raises the wake pulse
   a_stop_wake: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(o_lv_reset_req) && $past(i_stop_mode) |-> o_wake_pulse &&
         o_wake_vector == SVLR_RESET_VECTOR)
      else $error("reset in stop gave no wake");
endmodule
`default_nettype wire

//--- verification/svlr_cmp_model.sv
// behavioural supply comparator standing beside the low-voltage reset control
`timescale 1ns/100ps
`default_nettype none
module svlr_cmp_model #(
   parameter int LO_FALL_MV = 2600,
   parameter int LO_RISE_MV = 2700,
   parameter int HI_FALL_MV = 4000,
   parameter int HI_RISE_MV = 4100
) (
   input wire logic [15:0] i_supply_mv,   // supply level, millivolts
   input wire logic i_trip_level_select,  // higher threshold when high
   input wire logic i_monitor_power_en,   // comparator powered
   output logic o_below_fall,             // below falling trip
   output logic o_above_rise              // above rising trip
);
   int fall_mv;
   int rise_mv;
   assign fall_mv = i_trip_level_select ? HI_FALL_MV : LO_FALL_MV;
   assign rise_mv = i_trip_level_select ? HI_RISE_MV : LO_RISE_MV;
   // unpowered reports nothing; the gap between levels is the hysteresis
   assign o_below_fall = i_monitor_power_en && (int'(i_supply_mv) < fall_mv);
   assign o_above_rise = i_monitor_power_en && (int'(i_supply_mv) > rise_mv);
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the supply low-voltage reset control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import svlr_pkg::*;
   typedef struct packed {
      logic wr;
      logic [11:0] addr;
      logic [31:0] wdata;
      logic [31:0] exp;
      logic exp_err;
   } svlr_row_t;
   localparam logic [15:0] MV_LOW = 16'h07D0;
   localparam logic [15:0] MV_LO_GAP = 16'h0A5A;
   localparam logic [15:0] MV_NOM = 16'h0CE4;
   localparam logic [15:0] MV_HI_GAP = 16'h0FD2;
   localparam logic [15:0] MV_HIGH = 16'h1388;
   logic sys_clk, rst_n, por_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic below, above, wait_mode, stop_mode, pwr_en, trip_sel, req, pin_out, pin_oe, wake, err;
   logic [15:0] wake_vec, supply_mv;
   int mismatches, n_compared, w0;
   // only the wake counter process writes this after the start value
   int wake_cnt = 0;
   svlr_row_t rows [10];

   svlr_top dut_u (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_por_n(por_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_below_fall_async(below),
      .i_above_rise_async(above), .i_wait_mode(wait_mode), .i_stop_mode(stop_mode),
      .o_monitor_power_en(pwr_en), .o_trip_level_select(trip_sel), .o_lv_reset_req(req),
      .o_rst_pin_out(pin_out), .o_rst_pin_oe(pin_oe), .o_wake_pulse(wake),
      .o_wake_vector(wake_vec));
   svlr_cmp_model cmp_u (.i_supply_mv(supply_mv), .i_trip_level_select(trip_sel),
      .i_monitor_power_en(pwr_en), .o_below_fall(below), .o_above_rise(above));

   // ****************************************
   // clock, watchdog, helpers
   // ****************************************
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // run needs about 350 cycles; twelve and a half thousand means a hang
   initial begin
      #100000;
      mismatches++;
      print_verdict();
   end
   always @(posedge sys_clk) begin
      if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
   end

   task automatic print_verdict();
      if (mismatches == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one apb transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) mismatches++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle cycle so a following call never re-drives psel in this step
      @(posedge sys_clk);
   endtask

   task automatic wait_req(input logic lvl, input int lim);
      int n;
      n = 0;
      while (req !== lvl && n < lim) begin
         @(posedge sys_clk);
         n++;
      end
      chk("lv_reset_req", 32'(lvl), 32'(req));
   endtask

   task automatic hold(input int cyc);
      repeat (cyc) @(posedge sys_clk);
   endtask

   task automatic do_reset(input logic por);
      rst_n <= 1'b0;
      if (por) por_n <= 1'b0;
      hold(6);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      hold(2);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {rst_n, por_n, psel, penable, pwrite, wait_mode, stop_mode} = '0;
      paddr = '0;
      pwdata = '0;
      supply_mv = MV_NOM;
      mismatches = 0;
      n_compared = 0;
      rows = '{'{1'b0, SVLR_CFG_OFF, 32'h0, 32'h0, 1'b0},
               '{1'b0, SVLR_STATUS_OFF, 32'h0, 32'h0, 1'b0},
               '{1'b1, SVLR_CFG_OFF, 32'h6, 32'h0, 1'b0},
               '{1'b0, SVLR_CFG_OFF, 32'h0, 32'h6, 1'b0},
               '{1'b1, SVLR_STATUS_OFF, 32'hFF, 32'h0, 1'b0},
               '{1'b0, SVLR_STATUS_OFF, 32'h0, 32'h0, 1'b0},
               '{1'b0, 12'h008, 32'h0, 32'h0, 1'b1},
               '{1'b1, 12'h00C, 32'h5, 32'h0, 1'b1},
               '{1'b1, SVLR_CFG_OFF, 32'h0, 32'h0, 1'b0},
               '{1'b0, SVLR_CFG_OFF, 32'h0, 32'h0, 1'b0}};
      @(posedge sys_clk);
      do_reset(1'b1);
      chk("monitor_power_en", 32'h1, 32'(pwr_en));
      chk("trip_sel", 32'h0, 32'(trip_sel));
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].addr, rows[i].wdata);
         if (!rows[i].wr) chk("prdata", rows[i].exp, rd);
         chk("pslverr", 32'(rows[i].exp_err), 32'(err));
      end
      // fall, hysteresis hold, recovery
      supply_mv <= MV_LOW;
      wait_req(1'b1, 10);
      chk("rst_pin_oe", 32'h1, 32'(pin_oe));
      chk("rst_pin_out", 32'h0, 32'(pin_out));
      apb(1'b0, SVLR_STATUS_OFF, 32'h0);
      chk("status", 32'h80, rd);
      supply_mv <= MV_LO_GAP;
      hold(20);
      chk("held req", 32'h1, 32'(req));
      supply_mv <= MV_NOM;
      wait_req(1'b0, 10);
      apb(1'b0, SVLR_STATUS_OFF, 32'h0);
      chk("status", 32'h0, rd);
      // polled use, then flag held between levels and cleared by reset
      apb(1'b1, SVLR_CFG_OFF, 32'h2);
      supply_mv <= MV_LOW;
      hold(10);
      chk("polled req", 32'h0, 32'(req));
      apb(1'b0, SVLR_STATUS_OFF, 32'h0);
      chk("status", 32'h80, rd);
      supply_mv <= MV_LO_GAP;
      hold(10);
      apb(1'b0, SVLR_STATUS_OFF, 32'h0);
      chk("status", 32'h80, rd);
      do_reset(1'b0);
      hold(10);
      apb(1'b0, SVLR_STATUS_OFF, 32'h0);
      chk("status", 32'h0, rd);
      chk("req", 32'h0, 32'(req));
      supply_mv <= MV_NOM;
      // monitor powered down
      apb(1'b1, SVLR_CFG_OFF, 32'h1);
      hold(2);
      chk("monitor_power_en", 32'h0, 32'(pwr_en));
      supply_mv <= MV_LOW;
      hold(10);
      chk("req", 32'h0, 32'(req));
      apb(1'b1, SVLR_CFG_OFF, 32'h0);
      wait_req(1'b1, 20);
      supply_mv <= MV_NOM;
      wait_req(1'b0, 10);
      // wait mode wake
      wait_mode <= 1'b1;
      w0 = wake_cnt;
      supply_mv <= MV_LOW;
      wait_req(1'b1, 10);
      hold(3);
      chk("wake count", 32'h1, 32'(wake_cnt - w0));
      chk("wake_vector", 32'hFFFE, 32'(wake_vec));
      supply_mv <= MV_NOM;
      wait_req(1'b0, 10);
      wait_mode <= 1'b0;
      // stop mode, gated then enabled
      stop_mode <= 1'b1;
      supply_mv <= MV_LOW;
      hold(10);
      chk("stop req", 32'h0, 32'(req));
      w0 = wake_cnt;
      apb(1'b1, SVLR_CFG_OFF, 32'h4);
      wait_req(1'b1, 20);
      hold(3);
      chk("wake count", 32'h1, 32'(wake_cnt - w0));
      chk("wake_vector", 32'hFFFE, 32'(wake_vec));
      supply_mv <= MV_NOM;
      wait_req(1'b0, 10);
      stop_mode <= 1'b0;
      // higher threshold chosen while below its rising trip
      supply_mv <= MV_HI_GAP;
      apb(1'b1, SVLR_CFG_OFF, 32'h8);
      hold(2);
      chk("trip_sel", 32'h1, 32'(trip_sel));
      wait_req(1'b1, 200);
      supply_mv <= MV_HIGH;
      wait_req(1'b0, 10);
      // only power-on reset restores the lower threshold
      do_reset(1'b0);
      chk("trip_sel", 32'h1, 32'(trip_sel));
      do_reset(1'b1);
      chk("trip_sel", 32'h0, 32'(trip_sel));
      print_verdict();
   end
endmodule
`default_nettype wire
